// ### core/xul_defs.svh
`ifndef XUL_DEFS_SVH
`define XUL_DEFS_SVH
// bit positions and field values of the extended underline logic
`define XUL_EN_BIT        0
`define XUL_ROW_W         5
`define XUL_ATTR_FG_LSB   0
`define XUL_ATTR_FG_MSB   3
`define XUL_ATTR_BG_LSB   4
`define XUL_ATTR_BG_MSB   7
`define XUL_STD_UL_MASK   8'h77
`define XUL_STD_UL_VALUE  8'h01
`define XUL_BYTE_RESET    8'h00
`define XUL_NIB_RESET     4'h0
`define XUL_ADDR_RESET    16'h0000
`define XUL_SOLID_LINE    8'hff
`define XUL_DOT_LINE      8'h55
`define XUL_HALF_LINE     8'h0f
`define XUL_PIX_LAT       3
`endif

// ### core/xul_pkg.sv
package xul_pkg;
  // source of the pixel byte for the current character
  typedef enum logic [1:0] {
    SRC_FONT   = 2'b00,
    SRC_EXT_UL = 2'b01,
    SRC_STD_UL = 2'b10
  } pat_src_e;
endpackage : xul_pkg

// ### core/xul_pattern_sel.sv
`include "xul_defs.svh"
// picks the pixel byte for one character cell, purely combinational
module xul_pattern_sel (
  input  wire logic              ext_en,
  input  wire logic              on_ul_row,
  input  wire logic [7:0]        attr_byte,
  input  wire logic [7:0]        font_byte,
  input  wire logic [7:0]        ul_byte,
  output xul_pkg::pat_src_e      src,
  output logic      [7:0]        pattern
);
  wire std_ul_attr;
  wire use_ext;
  wire use_std;

  // standard underline only for the classic attribute, and only with extension off
  assign std_ul_attr = (attr_byte & `XUL_STD_UL_MASK) == `XUL_STD_UL_VALUE;
  assign use_ext     = ext_en & on_ul_row;
  assign use_std     = ~ext_en & on_ul_row & std_ul_attr;

  // any 8-bit pattern passes unaltered, so textures are up to software
  assign src     = use_ext ? xul_pkg::SRC_EXT_UL : use_std ? xul_pkg::SRC_STD_UL : xul_pkg::SRC_FONT;
  assign pattern = use_ext ? ul_byte : use_std ? `XUL_SOLID_LINE : font_byte;
endmodule : xul_pattern_sel

// ### core/xul_text_ext.sv
`include "xul_defs.svh"
module xul_text_ext (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  compat_ctrl_wdata,
  input  wire logic        compat_ctrl_we,
  input  wire logic [4:0]  underline_row,
  input  wire logic        wide_interleave_mode,
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [4:0]  row_scan,
  input  wire logic [7:0]  plane0_data,
  input  wire logic [7:0]  plane1_data,
  input  wire logic [7:0]  plane2_data,
  input  wire logic [7:0]  plane3_data,
  output logic             ext_ul_en,
  output logic             plane3_rd_q,
  output logic [15:0]      plane_addr_q,
  output logic [7:0]       font_code_q,
  output logic             pix_valid_q,
  output logic [7:0]       pix_pattern_q,
  output logic [3:0]       pix_fg_q,
  output logic [3:0]       pix_bg_q,
  output logic             pix_ext_ul_q
);
  logic              en_q;
  logic              fetch_q;
  logic              row_hit_q;
  logic [7:0]        attr_q;
  logic [7:0]        ul_q;
  logic              font_q;
  logic              row_hit2_q;
  logic              ext_q;
  xul_pkg::pat_src_e src;
  logic [7:0]        pattern;
  wire               ext_active;

  assign ext_ul_en = en_q;

  // enable flag; the wide interleaved text mode keeps fonts in plane 3 so it overrides
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b0;
    end else if (compat_ctrl_we) begin
      en_q <= compat_ctrl_wdata[`XUL_EN_BIT];
    end
  end
  assign ext_active = en_q & ~wide_interleave_mode;

  // stage 1: address planes 0, 1 and 3 with the character/attribute address
  // row match taken with the fetch, so a row register write cannot split a cell
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_q      <= 1'b0;
      plane_addr_q <= `XUL_ADDR_RESET;
      plane3_rd_q  <= 1'b0;
      row_hit_q    <= 1'b0;
    end else begin
      fetch_q      <= fetch_req;
      plane3_rd_q  <= fetch_req & ext_active;
      row_hit_q    <= row_scan == underline_row;
      if (fetch_req) begin
        plane_addr_q <= fetch_addr;
      end
    end
  end

  // stage 2: capture character, attribute and underline byte; font address goes out
  // ext_q rides with each cell, so an enable write mid-stream cannot mix sources
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      font_code_q <= `XUL_BYTE_RESET;
      attr_q      <= `XUL_BYTE_RESET;
      ul_q        <= `XUL_BYTE_RESET;
      font_q      <= 1'b0;
      row_hit2_q  <= 1'b0;
      ext_q       <= 1'b0;
    end else begin
      font_q     <= fetch_q;
      row_hit2_q <= row_hit_q;
      ext_q      <= plane3_rd_q;
      if (fetch_q) begin
        font_code_q <= plane0_data;
        attr_q      <= plane1_data;
        ul_q        <= plane3_rd_q ? plane3_data : `XUL_BYTE_RESET;
      end
    end
  end

  // font byte arrives from plane 2 in the same cycle as font_code_q, in step with attr_q and ul_q
  xul_pattern_sel u_sel (
    .ext_en    (ext_q),
    .on_ul_row (row_hit2_q),
    .attr_byte (attr_q),
    .font_byte (plane2_data),
    .ul_byte   (ul_q),
    .src       (src),
    .pattern   (pattern)
  );

  // stage 3: pixel byte with the cell's own colours
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_valid_q   <= 1'b0;
      pix_pattern_q <= `XUL_BYTE_RESET;
      pix_fg_q      <= `XUL_NIB_RESET;
      pix_bg_q      <= `XUL_NIB_RESET;
      pix_ext_ul_q  <= 1'b0;
    end else begin
      pix_valid_q   <= font_q;
      pix_pattern_q <= pattern;
      pix_fg_q      <= attr_q[`XUL_ATTR_FG_MSB:`XUL_ATTR_FG_LSB];
      pix_bg_q      <= attr_q[`XUL_ATTR_BG_MSB:`XUL_ATTR_BG_LSB];
      pix_ext_ul_q  <= src == xul_pkg::SRC_EXT_UL;
    end
  end

  // checks: reset masks every cell property, only the reset checks look through it
  // cell properties on pix_* look one edge past the stage 2 capture, where pix_* land; src checks look at the capture cycle
  // enable flag leaves reset cleared
  enable_reset_a: assert property (@(posedge core_clk)
    $rose(arst_n) |-> !en_q)
    else $error("enable not clear after reset");

  // pipeline outputs leave reset idle
  outputs_reset_a: assert property (@(posedge core_clk)
    $rose(arst_n) |-> !pix_valid_q && !plane3_rd_q && !pix_ext_ul_q)
    else $error("outputs not idle after reset");

  // a write takes the enable bit of the data
  enable_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    compat_ctrl_we |=> en_q == $past(compat_ctrl_wdata[`XUL_EN_BIT]))
    else $error("enable bit not taken");

  // without a write the enable holds
  enable_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !compat_ctrl_we |=> $stable(en_q))
    else $error("enable changed without write");

  // plane 3 read at the character address only while the feature is active
  plane3_fetch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetch_req |=> plane3_rd_q == $past(ext_active) && plane_addr_q == $past(fetch_addr))
    else $error("plane 3 fetch mismatch");

  // address stands between fetches
  addr_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !fetch_req |=> $stable(plane_addr_q))
    else $error("plane address moved without fetch");

  // an unread plane 3 never feeds a stale byte
  ul_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetch_q && !plane3_rd_q |=> ul_q == `XUL_BYTE_RESET)
    else $error("underline byte without plane 3 read");

  // one pixel byte a fixed number of edges after each fetch
  pix_latency_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetch_req |-> ##`XUL_PIX_LAT pix_valid_q)
    else $error("pixel byte late or missing");

  // underline row of an extended cell shows the plane 3 byte as it is
  ext_pattern_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && ext_q && row_hit2_q |=> pix_pattern_q == $past(ul_q))
    else $error("underline byte not used");

  // selector picks plane 3 on the underline row of an extended cell
  pattern_src_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && ext_q && row_hit2_q |-> src == xul_pkg::SRC_EXT_UL)
    else $error("wrong pattern source");

  // flag marks exactly the cells drawn from plane 3
  ext_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q |=> pix_ext_ul_q == $past(ext_q && row_hit2_q))
    else $error("extended flag wrong");

  // other rows draw the font byte
  font_pattern_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && !row_hit2_q |=> pix_pattern_q == $past(plane2_data))
    else $error("font byte not used");

  // colours come from the cell's own attribute
  colour_pass_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q |=> pix_fg_q == $past(attr_q[`XUL_ATTR_FG_MSB:`XUL_ATTR_FG_LSB])
    && pix_bg_q == $past(attr_q[`XUL_ATTR_BG_MSB:`XUL_ATTR_BG_LSB]))
    else $error("colours wrong");

  // classic underline never chosen while extended
  std_suppress_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && ext_q |-> src != xul_pkg::SRC_STD_UL)
    else $error("classic underline while extended");

  // classic attribute on the underline row gives a solid line
  std_underline_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && !ext_q && row_hit2_q && (attr_q & `XUL_STD_UL_MASK) == `XUL_STD_UL_VALUE
    |=> pix_pattern_q == `XUL_SOLID_LINE)
    else $error("classic underline missing");

  // any other attribute keeps its font byte on the underline row
  std_plain_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    font_q && !ext_q && row_hit2_q && (attr_q & `XUL_STD_UL_MASK) != `XUL_STD_UL_VALUE
    |=> pix_pattern_q == $past(plane2_data))
    else $error("underline on plain attribute");

  // wide interleaved text keeps fonts in plane 3, so it is never read as underline
  wide_block_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wide_interleave_mode |=> !plane3_rd_q)
    else $error("plane 3 read in wide mode");

  // main scenarios: extended line, classic line, dotted and half patterns, wide mode fetch
  ext_cell_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    pix_valid_q && pix_ext_ul_q);
  std_cell_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    font_q && src == xul_pkg::SRC_STD_UL);
  dotted_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    pix_ext_ul_q && pix_pattern_q == `XUL_DOT_LINE);
  half_line_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    pix_ext_ul_q && pix_pattern_q == `XUL_HALF_LINE);
  wide_fetch_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    fetch_req && wide_interleave_mode);
endmodule : xul_text_ext

// ### verification/mem_planes_model.sv
// video memory planes: contents are fixed functions of the address, plane 2 of the font code
module mem_planes_model (
  input  wire logic        plane3_rd_q,
  input  wire logic [15:0] plane_addr_q,
  input  wire logic [7:0]  font_code_q,
  output logic      [7:0]  plane0_data,
  output logic      [7:0]  plane1_data,
  output logic      [7:0]  plane2_data,
  output logic      [7:0]  plane3_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // char and attr planes answer in the same cycle as the address, with no read latency
  assign plane0_data = ~plane_addr_q[7:0]; // char code differs from the plane 3 byte, so a mixup shows
  assign plane1_data = plane_addr_q[15:8];
  // unread plane 3 shows the inverse, so a stale byte cannot pass
  assign plane3_data = plane3_rd_q ? plane_addr_q[7:0] : ~plane_addr_q[7:0];
  // font plane untouched by underline writes
  assign plane2_data = font_code_q ^ 8'ha5;
endmodule : mem_planes_model

// ### verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, arst_n, compat_ctrl_we, wide_interleave_mode, fetch_req, taken, cur_en;
  logic        ext_ul_en, plane3_rd_q, pix_valid_q, pix_ext_ul_q;
  logic [7:0]  compat_ctrl_wdata, p0, p1, p2, p3, font_code_q, pix_pattern_q;
  logic [4:0]  underline_row, row_scan;
  logic [15:0] fetch_addr, plane_addr_q;
  logic [3:0]  pix_fg_q, pix_bg_q;
  logic [16:0] pq[$];
  logic [16:0] aq[$];
  logic [31:0] seed;
  logic [7:0]  pats[4] = '{8'hff, 8'h55, 8'h0f, 8'h01};
  logic [7:0]  attrs[4] = '{8'h01, 8'h89, 8'h11, 8'h02};
  int          error_cnt, checked;
  xul_text_ext i_xul_text_ext (.core_clk(core_clk), .arst_n(arst_n), .compat_ctrl_wdata(compat_ctrl_wdata),
    .compat_ctrl_we(compat_ctrl_we), .underline_row(underline_row), .wide_interleave_mode(wide_interleave_mode),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .row_scan(row_scan), .plane0_data(p0), .plane1_data(p1),
    .plane2_data(p2), .plane3_data(p3), .ext_ul_en(ext_ul_en), .plane3_rd_q(plane3_rd_q),
    .plane_addr_q(plane_addr_q), .font_code_q(font_code_q), .pix_valid_q(pix_valid_q),
    .pix_pattern_q(pix_pattern_q), .pix_fg_q(pix_fg_q), .pix_bg_q(pix_bg_q), .pix_ext_ul_q(pix_ext_ul_q));
  mem_planes_model i_mem_planes_model (.plane3_rd_q(plane3_rd_q), .plane_addr_q(plane_addr_q),
    .font_code_q(font_code_q), .plane0_data(p0), .plane1_data(p1), .plane2_data(p2), .plane3_data(p3));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], ^(x & 32'h80200003)};
  endfunction : lfsr
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // one enable write, then the enable level is looked at
  task automatic cfg(input logic en, input logic wide, input logic [4:0] row);
    @(posedge core_clk);
    seed = lfsr(seed);
    compat_ctrl_we <= 1'b1;
    compat_ctrl_wdata <= {seed[6:0], en};
    wide_interleave_mode <= wide;
    underline_row <= row;
    cur_en = en & ~wide;
    @(posedge core_clk);
    compat_ctrl_we <= 1'b0;
    #1 chk({16'h0, ext_ul_en}, {16'h0, en});
  endtask : cfg
  // fetch_req stays high across calls, giving back-to-back cells
  task automatic fetch(input logic [15:0] a, input logic [4:0] r);
    logic m;
    logic [7:0] pat;
    m = (r == underline_row);
    pat = (cur_en && m) ? a[7:0] : (!cur_en && m && (a[15:8] & 8'h77) == 8'h01) ? 8'hff : a[7:0] ^ 8'h5a;
    @(posedge core_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    row_scan <= r;
    pq.push_back({pat, a[11:8], a[15:12], cur_en & m});
    aq.push_back({cur_en, a});
  endtask : fetch
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // marks the edge at which a fetch was taken
  always @(posedge core_clk) taken <= fetch_req;
  // outputs are settled by the falling edge
  always @(negedge core_clk) begin
    if (taken === 1'b1) chk({plane3_rd_q, plane_addr_q}, aq.pop_front());
    if (pix_valid_q === 1'b1) chk({pix_pattern_q, pix_fg_q, pix_bg_q, pix_ext_ul_q}, pq.pop_front());
  end
  initial begin
    {arst_n, compat_ctrl_we, wide_interleave_mode, fetch_req, cur_en, taken} = '0;
    {compat_ctrl_wdata, underline_row, row_scan, fetch_addr} = '0;
    seed = 32'h0de62958;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk({16'h0, ext_ul_en}, 17'h0);
    for (int m = 0; m < 4; m++) begin
      cfg(m[0], m[1], 5'h08 + 5'(m));
      for (int i = 0; i < 12; i++) begin
        seed = lfsr(seed);
        fetch(i < 4 ? {attrs[i], pats[i]} : seed[15:0], (i < 4 || i % 2 == 0) ? underline_row : seed[20:16]);
      end
      @(posedge core_clk);
      fetch_req <= 1'b0;
    end
    for (int k = 0; k < 10 && (pq.size() > 0 || aq.size() > 0); k++) @(posedge core_clk);
    if (pq.size() > 0 || aq.size() > 0) error_cnt++;
    // a reset in mid-run clears an enable that was set
    cfg(1'b1, 1'b0, 5'h00);
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk({14'h0, ext_ul_en, plane3_rd_q, pix_valid_q}, 17'h0);
    end_sim();
  end
endmodule : tb
